// file: rtl/config_lock_pkg.sv
// constants, types and carriers shared by the configuration loader
package config_lock_pkg;

  // ----------------------------------------------------------------
  // clock and start-up timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned STARTUP_UNIT_MS = 1;  // one step of the delay code
  localparam int unsigned CYCLES_PER_MS   = CLK_FREQ_HZ / 1000 * STARTUP_UNIT_MS;

  // ----------------------------------------------------------------
  // nonvolatile offsets and field layout
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_KEY       = 4'h0;
  localparam logic [3:0] OFS_OSC       = 4'h2;
  localparam logic [3:0] OFS_SYS0      = 4'h5;
  localparam logic [3:0] OFS_SYS1      = 4'h6;
  localparam logic [3:0] OFS_CODE      = 4'h7;
  localparam logic [3:0] OFS_BOOT      = 4'h8;
  localparam logic [3:0] KEY_BYTES     = 4'h4;
  localparam logic [3:0] LOAD_COUNT    = 4'h9;  // four key bytes, five config bytes
  localparam int         DEFAULT_CLOCK_CHOICE_MSB    = 3;
  localparam int         REGION_MSB    = 7;
  localparam int         REGION_LSB    = 6;
  localparam int         POLY_BIT      = 5;
  localparam int         RSTPIN_BIT    = 3;
  localparam int         EEKEEP_BIT    = 0;
  localparam int         SUPPLY_MSB    = 4;
  localparam int         SUPPLY_LSB    = 3;
  localparam int         SUT_MSB       = 2;
  localparam int         BLOCK_SHIFT   = 9;     // 512-byte blocks
  localparam int         LEN_W         = 17;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  CLK_FAST        = 4'h0;
  localparam logic [3:0]  CLK_SLOW        = 4'h1;
  localparam logic [1:0]  SUPPLY_DUAL     = 2'h1;
  localparam logic [1:0]  SUPPLY_SINGLE   = 2'h2;
  localparam logic [7:0]  BOOT_WHOLE      = 8'h00;
  localparam logic [31:0] UNLOCK_KEY      = 32'h5CC5_C55C;
  localparam logic [7:0]  DENIED_DATA     = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  typedef enum logic [1:0] {REGION_FLASH, REGION_BOOT, REGION_BOOTAPP, REGION_NONE} region_t;

  typedef enum logic [2:0] {
    SECT_FLASH, SECT_SRAM, SECT_EEPROM, SECT_USER_ROW_A,
    SECT_SIGNATURE_ROW, SECT_FUSE, SECT_LOCK, SECT_REGS
  } sect_t;

  typedef enum logic [1:0] {PH_LOAD, PH_WAIT, PH_RUN, PH_ERASE} phase_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       req;
    logic       we;
    sect_t      sect;
    logic [3:0] addr;
    logic [7:0] wdata;
  } access_t;

  typedef struct packed {
    logic       en;
    logic       lock;   // 1: lock area, 0: configuration area
    logic [3:0] addr;
    logic [7:0] data;
  } nvm_wr_t;

  typedef struct packed {
    logic             clk_slow;
    logic             clk_reserved;
    region_t          region;
    logic             poly_crc32;
    logic             reset_pin_en;
    logic             reset_pin_pullup;
    logic             eeprom_keep;
    logic             supply_dual;
    logic             supply_single;
    logic             supply_reserved;
    logic             boot_whole_flash;
    logic [LEN_W-1:0] boot_len_bytes;
    logic [LEN_W-1:0] code_len_bytes;
  } cfg_out_t;

endpackage

// file: rtl/config_word_decode_and_lock.sv
// configuration word loader, decoder and memory-section lock
//
// How it works
// - stored config is copied to output registers only at start-up end.
// - clock code 0 picks fast oscillator, 1 slow; others reserved.
// - word 0 bits 7:6 choose region checked by the flash scanner.
// - word 0 bit 5 picks CRC-16-CCITT or CRC-32 polynomial.
// - word 0 bit 3 enables external reset with pull-up.
// - word 0 bit 0 keeps EEPROM through chip erase.
// - word 1 bits 4:3 choose dual or single supply.
// - word 1 bits 2:0 set start-up delay 0 to 64 ms.
// - code length byte counts boot plus application in 512-byte blocks.
// - boot length byte counts boot section in 512-byte blocks.
// - boot length zero makes whole flash boot, code length ignored.
// - locked device blocks debug reads of memories and config.
// - unlock word readable by both, writable only by debug.
// - unlocked only when the word equals the unlock value.
// - unlocked access table for CPU and debug interface.
// - locked denies all debug access except user row writes.
// - denied debug reads complete but return invalid data.
// - locked user row writes accepted, reads refused.
// - only full chip erase unlocks; application data is erased.
`timescale 1ns/1ps
module config_word_decode_and_lock
  import config_lock_pkg::*;
#(
  parameter logic [31:0] MS_CYCLES = 32'(CYCLES_PER_MS)
) (
  input  wire logic        clock,        // system clock
  input  wire logic        nrst,         // synchronous reset, active low
  output logic             nvm_rd_en,    // nonvolatile read strobe
  output logic             nvm_rd_lock,  // read selects lock area
  output logic [3:0]       nvm_rd_addr,  // nonvolatile read offset
  input  wire logic [7:0]  nvm_rd_data,  // read data, cycle after strobe
  output nvm_wr_t          nvm_wr,       // nonvolatile write request
  output logic             erase_flash,  // erase flash pulse
  output logic             erase_eeprom, // erase eeprom pulse
  input  wire access_t     dbg,          // debug interface access
  input  wire logic        dbg_erase,    // debug chip erase request
  output logic             dbg_ready,    // debug requests taken
  output logic             dbg_ack,      // debug answer pulse
  output logic             dbg_denied,   // answered access was refused
  output logic [7:0]       dbg_rdata,    // debug read data
  output logic             dbg_mem_en,   // pass access to memory path
  input  wire logic [7:0]  mem_rdata,    // memory path read data
  input  wire access_t     cpu,          // cpu access
  output logic             cpu_allow,    // cpu access permitted
  output logic             cpu_ack,      // cpu answer pulse
  output logic [7:0]       cpu_rdata,    // cpu read data
  output logic             locked,       // device locked
  output logic             cfg_valid,    // start-up done, cpu may run
  output cfg_out_t         cfg           // decoded configuration
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t      phase;
    logic [3:0]  rd_idx;
    logic [3:0]  item;
    logic        rd_en;
    logic        cap_v;
    logic [3:0]  cap_idx;
    logic [31:0] key;
    logic [7:0]  osc;
    logic [7:0]  sys0;
    logic [7:0]  sys1;
    logic [7:0]  code;
    logic [7:0]  boot;
    logic [31:0] delay;
    logic [3:0]  er_idx;
    logic        locked;
    logic        run;
    cfg_out_t    cfg;
    logic        dbg_ack;
    logic        dbg_denied;
    logic [7:0]  dbg_rdata;
    logic        cpu_ack;
    logic [7:0]  cpu_rdata;
    nvm_wr_t     wr;
    logic        erase_flash;
    logic        erase_eeprom;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  logic [4:0] rd_sel;  // lock flag and offset of the byte being fetched

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // load order: key bytes first, then the configuration bytes
  function automatic logic [4:0] load_addr(input logic [3:0] idx);
    logic [4:0] a;
    a = {1'b0, OFS_OSC};
    if (idx < KEY_BYTES) begin
      a = {1'b1, OFS_KEY + idx};
    end else begin
      unique case (idx - KEY_BYTES)
        4'h0:    a = {1'b0, OFS_OSC};
        4'h1:    a = {1'b0, OFS_SYS0};
        4'h2:    a = {1'b0, OFS_SYS1};
        4'h3:    a = {1'b0, OFS_CODE};
        default: a = {1'b0, OFS_BOOT};
      endcase
    end
    return a;
  endfunction

  // configuration sections handled by this block, not by the memory path
  function automatic logic is_cfg_sect(input sect_t sect);
    return (sect == SECT_FUSE) || (sect == SECT_LOCK);
  endfunction

  // debug permission: a locked device leaves only user row writes open
  function automatic logic dbg_permit(input sect_t sect, input logic we, input logic lk);
    logic ok;
    if (lk) begin
      ok = we && (sect == SECT_USER_ROW_A);
    end else begin
      ok = !(we && (sect == SECT_SIGNATURE_ROW));
    end
    return ok;
  endfunction

  // cpu permission ignores the lock; read-only sections refuse writes
  function automatic logic cpu_permit(input sect_t sect, input logic we);
    logic ro;
    ro = (sect == SECT_SIGNATURE_ROW) || (sect == SECT_FUSE) || (sect == SECT_LOCK);
    return !(we && ro);
  endfunction

  // read one byte of the held key or configuration copy
  function automatic logic [7:0] cfg_byte(input state_t s, input sect_t sect,
                                          input logic [3:0] addr);
    logic [7:0] d;
    d = UNMAPPED_DATA;
    if (sect == SECT_LOCK) begin
      if (addr < KEY_BYTES) begin
        d = s.key[addr[1:0]*8 +: 8];
      end
    end else begin
      unique case (addr)
        OFS_OSC:  d = s.osc;
        OFS_SYS0: d = s.sys0;
        OFS_SYS1: d = s.sys1;
        OFS_CODE: d = s.code;
        OFS_BOOT: d = s.boot;
        default:  d = UNMAPPED_DATA;
      endcase
    end
    return d;
  endfunction

  // start-up delay in cycles: 0, then 1 ms doubling up to 64 ms
  function automatic logic [31:0] startup_cycles(input logic [2:0] startup_delay_select);
    logic [31:0] c;
    c = 32'h0000_0000;
    if (startup_delay_select != 3'h0) begin
      c = MS_CYCLES << (startup_delay_select - 3'h1);
    end
    return c;
  endfunction

  // decode the held bytes into the published configuration
  function automatic cfg_out_t cfg_decode(input state_t s);
    cfg_out_t c;
    logic [3:0] ck;
    logic [1:0] sup;
    ck                 = s.osc[DEFAULT_CLOCK_CHOICE_MSB:0];
    sup                = s.sys1[SUPPLY_MSB:SUPPLY_LSB];
    c.clk_slow         = (ck == CLK_SLOW);
    c.clk_reserved     = (ck != CLK_FAST) && (ck != CLK_SLOW);
    c.region           = region_t'(s.sys0[REGION_MSB:REGION_LSB]);
    c.poly_crc32       = s.sys0[POLY_BIT];
    c.reset_pin_en     = s.sys0[RSTPIN_BIT];
    c.reset_pin_pullup = s.sys0[RSTPIN_BIT];
    c.eeprom_keep      = s.sys0[EEKEEP_BIT];
    c.supply_dual      = (sup == SUPPLY_DUAL);
    c.supply_single    = (sup == SUPPLY_SINGLE);
    c.supply_reserved  = (sup != SUPPLY_DUAL) && (sup != SUPPLY_SINGLE);
    c.boot_whole_flash = (s.boot == BOOT_WHOLE);
    c.boot_len_bytes   = LEN_W'(s.boot) << BLOCK_SHIFT;
    if (s.boot == BOOT_WHOLE) begin
      c.code_len_bytes = '0;
    end else begin
      c.code_len_bytes = LEN_W'(s.code) << BLOCK_SHIFT;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic permit;
    permit             = 1'b0;
    s_nxt              = s_r;
    s_nxt.dbg_ack      = 1'b0;
    s_nxt.cpu_ack      = 1'b0;
    s_nxt.wr.en        = 1'b0;
    s_nxt.erase_flash  = 1'b0;
    s_nxt.erase_eeprom = 1'b0;
    s_nxt.rd_en        = 1'b0;

    // capture a byte read two cycles after issue
    s_nxt.cap_v   = s_r.rd_en;
    s_nxt.cap_idx = s_r.item;
    if (s_r.cap_v) begin
      if (s_r.cap_idx < KEY_BYTES) begin
        s_nxt.key[s_r.cap_idx[1:0]*8 +: 8] = nvm_rd_data;
      end else begin
        unique case (s_r.cap_idx - KEY_BYTES)
          4'h0:    s_nxt.osc  = nvm_rd_data;
          4'h1:    s_nxt.sys0 = nvm_rd_data;
          4'h2:    s_nxt.sys1 = nvm_rd_data;
          4'h3:    s_nxt.code = nvm_rd_data;
          default: s_nxt.boot = nvm_rd_data;
        endcase
      end
    end

    unique case (s_r.phase)
      // issue reads of the four key bytes and the five configuration bytes
      PH_LOAD: begin
        if (s_r.rd_idx != LOAD_COUNT) begin
          s_nxt.rd_en  = 1'b1;
          s_nxt.item   = s_r.rd_idx;
          s_nxt.rd_idx = s_r.rd_idx + 4'h1;
        end else if (!s_r.rd_en && !s_r.cap_v) begin
          // last fetched byte has landed, so the delay code is current
          s_nxt.delay = startup_cycles(s_r.sys1[SUT_MSB:0]);
          s_nxt.phase = PH_WAIT;
        end
      end
      // hold execution for the start-up delay, then publish config
      PH_WAIT: begin
        if (s_r.delay == 32'h0000_0000) begin
          s_nxt.cfg   = cfg_decode(s_r);
          s_nxt.run   = 1'b1;
          s_nxt.phase = PH_RUN;
        end else begin
          s_nxt.delay = s_r.delay - 32'h0000_0001;
        end
      end
      // serve accesses; chip erase takes priority
      PH_RUN: begin
        if (dbg_erase) begin
          s_nxt.erase_flash  = 1'b1;
          s_nxt.erase_eeprom = !s_r.sys0[EEKEEP_BIT];
          s_nxt.er_idx       = 4'h0;
          s_nxt.phase        = PH_ERASE;
        end else if (dbg.req) begin
          permit           = dbg_permit(dbg.sect, dbg.we, s_r.locked);
          s_nxt.dbg_ack    = 1'b1;
          s_nxt.dbg_denied = !permit;
          if (!dbg.we) begin
            if (!permit) begin
              s_nxt.dbg_rdata = DENIED_DATA;
            end else if (is_cfg_sect(dbg.sect)) begin
              s_nxt.dbg_rdata = cfg_byte(s_r, dbg.sect, dbg.addr);
            end else begin
              s_nxt.dbg_rdata = mem_rdata;
            end
          end else if (permit && is_cfg_sect(dbg.sect)) begin
            // stored only; takes effect after the next reset
            s_nxt.wr.en   = 1'b1;
            s_nxt.wr.lock = (dbg.sect == SECT_LOCK);
            s_nxt.wr.addr = dbg.addr;
            s_nxt.wr.data = dbg.wdata;
          end
        end
        // cpu config reads come from the start-up copy, never live storage
        if (cpu.req) begin
          s_nxt.cpu_ack = 1'b1;
          if (!cpu.we && is_cfg_sect(cpu.sect)) begin
            s_nxt.cpu_rdata = cfg_byte(s_r, cpu.sect, cpu.addr);
          end
        end
      end
      // rewrite the key to the unlock value after erasing
      PH_ERASE: begin
        s_nxt.wr.en   = 1'b1;
        s_nxt.wr.lock = 1'b1;
        s_nxt.wr.addr = OFS_KEY + s_r.er_idx;
        s_nxt.wr.data = UNLOCK_KEY[s_r.er_idx[1:0]*8 +: 8];
        s_nxt.er_idx  = s_r.er_idx + 4'h1;
        if (s_r.er_idx == KEY_BYTES - 4'h1) begin
          s_nxt.key   = UNLOCK_KEY;
          s_nxt.phase = PH_RUN;
        end
      end
    endcase

    // lock follows the held key copy, so an erase unlocks together with the last key byte write
    s_nxt.locked = (s_nxt.key != UNLOCK_KEY);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset restarts the load and stays locked until the key is read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r        <= '0;
      s_r.phase  <= PH_LOAD;
      s_r.locked <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // nonvolatile read port comes straight from the state
  assign nvm_rd_en    = s_r.rd_en;
  assign rd_sel       = load_addr(s_r.item);
  assign nvm_rd_lock  = rd_sel[4];
  assign nvm_rd_addr  = rd_sel[3:0];
  assign nvm_wr       = s_r.wr;
  assign erase_flash  = s_r.erase_flash;
  assign erase_eeprom = s_r.erase_eeprom;

  // debug handshake and memory path gate
  assign dbg_ready  = (s_r.phase == PH_RUN);
  assign dbg_ack    = s_r.dbg_ack;
  assign dbg_denied = s_r.dbg_denied;
  assign dbg_rdata  = s_r.dbg_rdata;
  assign dbg_mem_en = dbg_ready && dbg.req && !dbg_erase && !is_cfg_sect(dbg.sect)
                      && dbg_permit(dbg.sect, dbg.we, s_r.locked);

  // cpu side never depends on the lock state
  assign cpu_allow = dbg_ready && cpu.req && cpu_permit(cpu.sect, cpu.we);
  assign cpu_ack   = s_r.cpu_ack;
  assign cpu_rdata = s_r.cpu_rdata;

  assign locked    = s_r.locked;
  assign cfg_valid = s_r.run;
  assign cfg       = s_r.cfg;

endmodule

// file: verification/config_lock_checker_assertions.sv
// concurrent checks on the configuration loader ports
`timescale 1ns/1ps
module config_lock_checker
  import config_lock_pkg::*;
(
  input wire logic       clock,        // system clock
  input wire logic       nrst,         // synchronous reset, active low
  input wire logic       nvm_rd_en,    // nonvolatile read strobe
  input wire nvm_wr_t    nvm_wr,       // nonvolatile write request
  input wire logic       erase_flash,  // erase flash pulse
  input wire logic       erase_eeprom, // erase eeprom pulse
  input wire access_t    dbg,          // debug access
  input wire logic       dbg_erase,    // debug chip erase request
  input wire logic       dbg_ready,    // debug requests taken
  input wire logic       dbg_ack,      // debug answer pulse
  input wire logic       dbg_denied,   // answered access refused
  input wire logic [7:0] dbg_rdata,    // debug read data
  input wire logic       dbg_mem_en,   // memory path pass
  input wire access_t    cpu,          // cpu access
  input wire logic       cpu_allow,    // cpu permit
  input wire logic       locked,       // device locked
  input wire logic       cfg_valid,    // start-up done
  input wire cfg_out_t   cfg           // decoded configuration
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic take;  // debug access taken at this edge
  assign take = dbg_ready && dbg.req && !dbg_erase;

  // debug answer timing and refusals
  a_ack_follows_take: assert property (take |=> dbg_ack)
    else $error("debug access not answered");
  a_ack_has_cause: assert property (dbg_ack |-> $past(take))
    else $error("debug answer without request");
  a_locked_read_blank: assert property (take && locked && !dbg.we |=>
    dbg_denied && dbg_rdata == DENIED_DATA) else $error("locked debug read not blanked");
  a_locked_row_write: assert property (take && locked && dbg.we &&
    dbg.sect == SECT_USER_ROW_A |=> !dbg_denied) else $error("locked row write refused");
  a_locked_mem_gate: assert property (dbg_mem_en && locked |->
    dbg.we && dbg.sect == SECT_USER_ROW_A) else $error("locked memory path opened");
  // cpu side never writes the read-only sections
  a_cpu_ro_sections: assert property (cpu.req && cpu.we &&
    cpu.sect inside {SECT_SIGNATURE_ROW, SECT_FUSE, SECT_LOCK} |-> !cpu_allow)
    else $error("cpu write to read-only section permitted");
  // chip erase sequence
  a_eeprom_with_flash: assert property (erase_eeprom |-> erase_flash)
    else $error("eeprom erase without flash erase");
  a_erase_key_write: assert property (erase_flash |=> nvm_wr.en && nvm_wr.lock &&
    nvm_wr.addr == 4'h0 && nvm_wr.data == 8'h5C ##3 nvm_wr.en && nvm_wr.addr == 4'h3)
    else $error("erase does not rewrite the unlock word");
  a_erase_unlocks: assert property (erase_flash |-> ##4 !locked && dbg_ready)
    else $error("erase does not unlock in time");
  // configuration copied once at start-up
  a_cfg_frozen: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg))
    else $error("decoded configuration changed while running");
  a_load_before_run: assert property (nvm_rd_en |-> !cfg_valid && !dbg_ready)
    else $error("nonvolatile read after start-up");
endmodule

bind config_word_decode_and_lock config_lock_checker chk_i (.clock, .nrst, .nvm_rd_en,
  .nvm_wr, .erase_flash, .erase_eeprom, .dbg, .dbg_erase, .dbg_ready, .dbg_ack,
  .dbg_denied, .dbg_rdata, .dbg_mem_en, .cpu, .cpu_allow, .locked, .cfg_valid, .cfg);

// file: verification/nvm_model.sv
// nonvolatile store answering the loader's reads and writes
`timescale 1ns/1ps
module nvm_model
  import config_lock_pkg::*;
(
  input  wire logic       clock,   // system clock
  input  wire logic       rd_en,   // read strobe
  input  wire logic       rd_lock, // lock area select
  input  wire logic [3:0] rd_addr, // read offset
  output logic      [7:0] rd_data, // data one cycle after strobe
  input  wire nvm_wr_t    wr       // write request
);
  logic [7:0] key_b [4];   // lock word, byte n is bits 8n+7:8n
  logic [7:0] cfg_b [16];  // configuration bytes
  initial rd_data = 8'h00;
  // answer a strobe next cycle, scramble the bus when idle
  always @(posedge clock) begin
    if (rd_en) begin
      rd_data <= rd_lock ? key_b[rd_addr[1:0]] : cfg_b[rd_addr];
    end else begin
      rd_data <= ~rd_data;
    end
    if (wr.en && wr.lock) begin
      key_b[wr.addr[1:0]] <= wr.data;
    end else if (wr.en) begin
      cfg_b[wr.addr] <= wr.data;
    end
  end
endmodule

// file: verification/config_word_decode_and_lock_test.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module config_word_decode_and_lock_test;
  import config_lock_pkg::*;
  logic        clock = 1'b0;      // system clock
  logic        nrst = 1'b0;       // reset, active low
  logic        nvm_rd_en, nvm_rd_lock, erase_flash, erase_eeprom;
  logic [3:0]  nvm_rd_addr;
  logic [7:0]  nvm_rd_data, dbg_rdata, cpu_rdata;
  logic [7:0]  mem_rdata = 8'h00;
  nvm_wr_t     nvm_wr;
  access_t     dbg = '0;
  access_t     cpu = '0;
  logic        dbg_erase = 1'b0;
  logic        dbg_ready, dbg_ack, dbg_denied, dbg_mem_en;
  logic        cpu_allow, cpu_ack, locked, cfg_valid;
  cfg_out_t    cfg;
  int          n_mismatch = 0, n_tests = 0, cnt, dly;
  logic [31:0] key;
  logic [7:0]  osc, s0, s1, cs, bs, d, md, ex;
  logic [3:0]  a;
  logic        lk, we, den;
  sect_t       s;

  config_word_decode_and_lock #(.MS_CYCLES(32'h0000_000A)) config_word_decode_and_lock_i (
    .clock, .nrst, .nvm_rd_en, .nvm_rd_lock, .nvm_rd_addr, .nvm_rd_data, .nvm_wr,
    .erase_flash, .erase_eeprom, .dbg, .dbg_erase, .dbg_ready, .dbg_ack, .dbg_denied,
    .dbg_rdata, .dbg_mem_en, .mem_rdata, .cpu, .cpu_allow, .cpu_ack, .cpu_rdata, .locked,
    .cfg_valid, .cfg);
  nvm_model nvm_i (.clock, .rd_en(nvm_rd_en), .rd_lock(nvm_rd_lock), .rd_addr(nvm_rd_addr),
    .rd_data(nvm_rd_data), .wr(nvm_wr));

  always #5 clock = ~clock;

  // compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // reference decode of the stored bytes
  function automatic cfg_out_t exp_cfg();
    cfg_out_t e;
    e.clk_slow = (osc == 1);
    e.clk_reserved = (osc > 1);
    e.region = region_t'(s0[7:6]);
    e.poly_crc32 = s0[5];
    e.reset_pin_en = s0[3];
    e.reset_pin_pullup = s0[3];
    e.eeprom_keep = s0[0];
    e.supply_dual = (s1[4:3] == 1);
    e.supply_single = (s1[4:3] == 2);
    e.supply_reserved = (s1[4:3] == 0 || s1[4:3] == 3);
    e.boot_whole_flash = (bs == 0);
    e.boot_len_bytes = LEN_W'(bs * 512);
    e.code_len_bytes = (bs == 0) ? '0 : LEN_W'(cs * 512);
    return e;
  endfunction

  // watchdog
  initial begin
    #500_000;
    n_mismatch++;
    stop_test();
  end

  // one start-up per delay code, then every section both ways, then erase
  initial begin
    void'($urandom(32'he870));
    for (int i = 0; i < 8; i++) begin
      key = (i == 2) ? UNLOCK_KEY ^ 32'h0000_0001 : (i % 3 == 1) ? UNLOCK_KEY : $urandom;
      osc = 8'($urandom_range(3));
      s0 = 8'($urandom);
      s1 = {3'b000, 2'($urandom), 3'(i)};
      cs = 8'($urandom);
      bs = (i == 3) ? 8'h00 : 8'($urandom);
      for (int b = 0; b < 4; b++) nvm_i.key_b[b] = key[8*b +: 8];
      nvm_i.cfg_b[2] = osc;
      nvm_i.cfg_b[5] = s0;
      nvm_i.cfg_b[6] = s1;
      nvm_i.cfg_b[7] = cs;
      nvm_i.cfg_b[8] = bs;
      nrst = 1'b0;
      repeat (6) @(posedge clock);
      #1 nrst = 1'b1;
      cnt = 0;
      while (cfg_valid !== 1'b1 && cnt < 2000) begin
        @(posedge clock);
        #1 cnt++;
      end
      dly = (i == 0) ? 0 : (1 << (i - 1)) * 10;
      check("start-up delay", cnt >= dly + 9 && cnt <= dly + 20, 1'b1);
      check("decoded config", cfg, exp_cfg());
      lk = (key !== UNLOCK_KEY);
      check("lock state", locked, lk);
      for (int k = 0; k < 16; k++) begin
        s = sect_t'(3'(k));
        we = (k >= 8);
        a = (s == SECT_LOCK) ? 4'h0 : 4'h5;
        d = 8'($urandom);
        den = lk ? !(we && s == SECT_USER_ROW_A) : (we && s == SECT_SIGNATURE_ROW);
        dbg = '{req: 1'b1, we: we, sect: s, addr: a, wdata: d};
        cpu = '{req: 1'b1, we: we, sect: s, addr: a, wdata: ~d};
        mem_rdata = 8'($urandom);
        @(negedge clock);
        check("debug memory pass", dbg_mem_en, !den && !(s inside {SECT_FUSE, SECT_LOCK}));
        check("cpu permit", cpu_allow, !(we && s inside {SECT_SIGNATURE_ROW, SECT_FUSE, SECT_LOCK}));
        md = mem_rdata;
        @(posedge clock);
        #1;
        dbg = '{req: 1'b0, we: ~we, sect: s, addr: ~a, wdata: ~d};
        cpu = '{req: 1'b0, we: ~we, sect: s, addr: ~a, wdata: d};
        mem_rdata = ~md;
        check("debug answer", {dbg_ack, dbg_denied}, {1'b1, den});
        ex = (s == SECT_FUSE) ? s0 : (s == SECT_LOCK) ? key[7:0] : md;
        if (!we) check("debug read data", dbg_rdata, den ? DENIED_DATA : ex);
        if (!we && s inside {SECT_FUSE, SECT_LOCK}) check("cpu read", {cpu_ack, cpu_rdata}, {1'b1, ex});
        check("nv write", nvm_wr.en, we && !den && s inside {SECT_FUSE, SECT_LOCK});
        if (we && !den && s == SECT_LOCK) check("key byte", {nvm_wr.lock, nvm_wr.data}, {1'b1, d});
        @(posedge clock);
        #1 check("answer stands one cycle", {dbg_ack, cpu_ack}, 2'b00);
      end
      check("config after writes", cfg, exp_cfg());
      dbg_erase = 1'b1;
      @(posedge clock);
      #1 dbg_erase = 1'b0;
      check("erase pulses", {erase_flash, erase_eeprom}, {1'b1, !s0[0]});
      cnt = 0;
      while (dbg_ready !== 1'b1 && cnt < 20) begin
        @(posedge clock);
        #1 cnt++;
      end
      // last key byte lands in storage one edge after its write pulse
      @(posedge clock);
      #1;
      check("erase unlock", {cnt <= 4, locked, nvm_i.key_b[3], nvm_i.key_b[2], nvm_i.key_b[1],
        nvm_i.key_b[0]}, {1'b1, 1'b0, UNLOCK_KEY});
    end
    stop_test();
  end
endmodule
